// ### core/link_health_supervisor.v
// interdivision serial link health supervisor, two links
`timescale 1ns/1ps
`include "link_health_consts.vh"
module serial_link_health_supervisor #(
  parameter DW            = `DATA_W,
  parameter KEEPALIVE_CYC = `KEEPALIVE_CYC,
  parameter SILENCE_CYC   = `SILENCE_CYC
) (
  input  wire          ref_clk_i,      // 200 MHz clock
  input  wire          reset_n_i,      // sync reset, low
  input  wire [DW-1:0] app_tx_data_i,  // application word
  input  wire          app_tx_valid_i, // application request
  output reg           app_tx_ready_o, // buffer room, registered one cycle late
  output reg  [DW-1:0] tx_true_o,      // true copy, both lines
  output reg  [DW-1:0] tx_inv_o,       // inverse copy
  output reg  [15:0]   tx_crc_o,       // frame crc
  output reg  [1:0]    tx_valid_o,     // strobe per transmit line
  output reg           tx_keepalive_o, // keep-alive marker
  input  wire          tx_ready_i,     // both lines ready
  input  wire [2*DW-1:0] rx_true_i,    // true copy per link
  input  wire [2*DW-1:0] rx_inv_i,     // inverse copy per link
  input  wire [31:0]   rx_crc_i,       // received crc per link
  input  wire [1:0]    rx_keepalive_i, // keep-alive marker per link
  input  wire [1:0]    rx_valid_i,     // frame strobe per link
  output reg  [2*DW-1:0] mem_wr_data_o,// word to shared memory
  output reg  [1:0]    mem_wr_o,       // write strobe per link
  output reg  [1:0]    crc_err_o,      // crc error pulse per link
  output reg  [1:0]    data_fail_o,    // copy mismatch pulse
  output reg  [1:0]    link_failed_o,  // link failed level
  output reg  [1:0]    silence_o,      // silence timeout level
  output reg  [1:0]    burst_fail_o    // disturbed-ratio level
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  function [15:0] crc16;
    input [2*DW-1:0] d;
    integer k;
    reg [15:0] c;
    begin
      c = `CRC_INIT;
      for (k = 2*DW-1; k >= 0; k = k - 1)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `CRC_POLY : 16'h0000);
      crc16 = c;
    end
  endfunction

  // transmit side
  wire [DW-1:0] buf_data;
  wire          buf_valid;
  wire          buf_in_ready;
  reg           buf_pop;
  reg           tx_state;
  reg  [31:0]   idle_cnt;

  skid_buffer #(.W(DW)) u_txbuf (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .in_data_i  (app_tx_data_i),
    .in_valid_i (app_tx_valid_i),
    .in_ready_o (buf_in_ready),
    .out_data_o (buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop)
  );

  always @* begin
    buf_pop = (tx_state == ST_IDLE) & buf_valid;
  end

  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      tx_state       <= ST_IDLE;
      idle_cnt       <= 32'd0;
      tx_true_o      <= {DW{1'b0}};
      tx_inv_o       <= {DW{1'b0}};
      tx_crc_o       <= 16'h0000;
      tx_valid_o     <= 2'b00;
      tx_keepalive_o <= 1'b0;
      app_tx_ready_o <= 1'b0;
    end else begin
      app_tx_ready_o <= buf_in_ready;
      if (app_tx_valid_i)
        idle_cnt <= 32'd0;
      else if (idle_cnt < KEEPALIVE_CYC)
        idle_cnt <= idle_cnt + 32'd1;
      case (tx_state)
        ST_IDLE: begin
          if (buf_valid) begin
            tx_true_o      <= buf_data;
            tx_inv_o       <= ~buf_data;
            tx_crc_o       <= crc16({buf_data, ~buf_data});
            tx_valid_o     <= 2'b11;
            tx_keepalive_o <= 1'b0;
            tx_state       <= ST_SEND;
          end else if (idle_cnt >= KEEPALIVE_CYC - 1) begin
            tx_true_o      <= `KA_PATTERN;
            tx_inv_o       <= ~`KA_PATTERN;
            tx_crc_o       <= crc16({`KA_PATTERN, ~`KA_PATTERN});
            tx_valid_o     <= 2'b11;
            tx_keepalive_o <= 1'b1;
            idle_cnt       <= 32'd0;
            tx_state       <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_ready_i) begin
            tx_valid_o <= 2'b00;
            tx_state   <= ST_IDLE;
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // receive side, one supervisor per link
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_rx
      wire [DW-1:0] t = rx_true_i[g*DW +: DW];
      wire [DW-1:0] v = rx_inv_i[g*DW +: DW];
      wire crc_bad = crc16({t, v}) != rx_crc_i[g*16 +: 16];
      wire cmp_bad = (t != ~v);
      wire disturbed = crc_bad | cmp_bad;
      reg  [6:0]  slot;
      reg  [6:0]  dist_cnt;
      reg  [6:0]  clean_run;
      reg  [31:0] quiet;
      reg         pend;
      reg         pend_dist;
      reg  [6:0]  filled;
      wire        old_bit;

      frame_history #(.DEPTH(`WINDOW_FRAMES), .AW(7)) u_hist (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_i     (rx_valid_i[g]),
        .addr_i   (slot),
        .bit_i    (disturbed),
        .old_o    (old_bit)
      );

      wire [6:0] next_dist = dist_cnt + {6'd0, pend_dist}
                             - {6'd0, old_bit & (filled == `WINDOW_FRAMES)};

      always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          slot      <= 7'd0;
          dist_cnt  <= 7'd0;
          clean_run <= 7'd0;
          quiet     <= 32'd0;
          pend      <= 1'b0;
          pend_dist <= 1'b0;
          filled    <= 7'd0;
          mem_wr_data_o[g*DW +: DW] <= {DW{1'b0}};
          mem_wr_o[g]      <= 1'b0;
          crc_err_o[g]     <= 1'b0;
          data_fail_o[g]   <= 1'b0;
          link_failed_o[g] <= 1'b0;
          silence_o[g]     <= 1'b0;
          burst_fail_o[g]  <= 1'b0;
        end else begin
          pend <= rx_valid_i[g];
          pend_dist <= disturbed;
          mem_wr_o[g]    <= rx_valid_i[g] & ~crc_bad & ~cmp_bad
                            & ~rx_keepalive_i[g];
          mem_wr_data_o[g*DW +: DW] <= t;
          crc_err_o[g]   <= rx_valid_i[g] & crc_bad;
          data_fail_o[g] <= rx_valid_i[g] & ~crc_bad & cmp_bad;
          if (rx_valid_i[g]) begin
            slot  <= (slot == `WINDOW_FRAMES - 1) ? 7'd0 : slot + 7'd1;
            quiet <= 32'd0;
            clean_run <= disturbed ? 7'd0 :
                         (clean_run < 7'd100 ? clean_run + 7'd1 : clean_run);
          end else if (quiet < SILENCE_CYC) begin
            quiet <= quiet + 32'd1;
          end
          if (pend) begin
            dist_cnt <= next_dist;
            if (filled < `WINDOW_FRAMES) filled <= filled + 7'd1;
          end
          if (quiet >= SILENCE_CYC - 1 && !rx_valid_i[g]) begin
            silence_o[g]     <= 1'b1;
            link_failed_o[g] <= 1'b1;
            clean_run        <= 7'd0;
          end else if (pend && next_dist > `MAX_DISTURBED) begin
            burst_fail_o[g]  <= 1'b1;
            link_failed_o[g] <= 1'b1;
          end else if (clean_run >= `RECOVER_FRAMES) begin
            link_failed_o[g] <= 1'b0;
            silence_o[g]     <= 1'b0;
            burst_fail_o[g]  <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // serial_link_health_supervisor

// ### core/link_health_consts.vh
// constants for the interdivision serial link health supervisor
// Function
// - every frame carries a crc and the receiver checks it on each frame.
// - data is sent true and inverted; a copy mismatch marks it failed.
// - the link fails when over 3 of 100 consecutive frames are disturbed.
// - a crc error keeps data out of shared dual-port memory and is flagged.
// - a failed link recovers by itself after 100 error-free frames.
// - a keep-alive frame is sent when nothing was requested for 25 ms.
// - the link is declared failed when no frame arrived for 250 ms.
// - every detected error is reported as status to the application.
// - two links each with one transmit and one receive line are provided.
// - identical data is driven onto both transmit lines at the same time.
`ifndef LINK_HEALTH_CONSTS_VH
`define LINK_HEALTH_CONSTS_VH
`define CLK_MHZ          200
`define WINDOW_FRAMES    100
`define MAX_DISTURBED    3
`define RECOVER_FRAMES   100
`define KEEPALIVE_MS     25
`define SILENCE_MS       250
`define CYC_PER_MS       (`CLK_MHZ * 1000)
`define KEEPALIVE_CYC    (`KEEPALIVE_MS * `CYC_PER_MS)
`define SILENCE_CYC      (`SILENCE_MS * `CYC_PER_MS)
`define DATA_W           16
`define CRC_W            16
`define CRC_POLY         16'h1021
`define CRC_INIT         16'hffff
`define KA_PATTERN       16'h0000
`endif

// ### core/skid_buffer.v
// two-entry valid/ready buffer
`timescale 1ns/1ps
module skid_buffer #(
  parameter W = 16
) (
  input  wire         ref_clk_i,  // clock
  input  wire         reset_n_i,  // sync reset, low
  input  wire [W-1:0] in_data_i,  // input word
  input  wire         in_valid_i, // input valid
  output wire         in_ready_o, // room available
  output wire [W-1:0] out_data_o, // output word
  output wire         out_valid_o,// output valid
  input  wire         out_ready_i // receiver ready
);
  reg [W-1:0] mem0;
  reg [W-1:0] mem1;
  reg [1:0]   cnt;
  wire        push;
  wire        pop;
  assign in_ready_o  = (cnt != 2'd2);
  assign out_valid_o = (cnt != 2'd0);
  assign out_data_o  = mem0;
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt  <= 2'd0;
      mem0 <= {W{1'b0}};
      mem1 <= {W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt == 2'd0) mem0 <= in_data_i;
          else mem1 <= in_data_i;
          cnt <= cnt + 2'd1;
        end
        2'b01: begin
          mem0 <= mem1;
          cnt  <= cnt - 2'd1;
        end
        2'b11: begin
          if (cnt == 2'd1) mem0 <= in_data_i;
          else begin
            mem0 <= mem1;
            mem1 <= in_data_i;
          end
        end
        default: cnt <= cnt;
      endcase
    end
  end
endmodule // skid_buffer

// ### core/frame_history.v
// 100-entry disturbed-frame history for the sliding window
`timescale 1ns/1ps
module frame_history #(
  parameter DEPTH = 100,
  parameter AW    = 7
) (
  input  wire          ref_clk_i, // clock
  input  wire          reset_n_i, // sync reset, low
  input  wire          wr_i,      // store a frame outcome
  input  wire [AW-1:0] addr_i,    // slot index
  input  wire          bit_i,     // disturbed flag
  output reg           old_o      // flag previously in slot
);
  reg [DEPTH-1:0] hist;
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      hist  <= {DEPTH{1'b0}};
      old_o <= 1'b0;
    end else begin
      old_o <= hist[addr_i];
      if (wr_i) hist[addr_i] <= bit_i;
    end
  end
endmodule // frame_history

// ### tb/link_health_checker.sv
// concurrent checks on the link health supervisor ports
`timescale 1ns/1ps
module link_health_checker #(
  parameter KEEPALIVE_CYC = 50
) (
  input wire        ref_clk_i,      // clock
  input wire        reset_n_i,      // reset
  input wire        app_tx_valid_i, // request
  input wire [15:0] tx_true_o,      // true copy
  input wire [1:0]  tx_valid_o,     // strobes
  input wire        tx_ready_i,     // ready
  input wire [31:0] rx_true_i,      // rx true
  input wire [31:0] rx_inv_i,       // rx inverse
  input wire [31:0] rx_crc_i,       // rx crc
  input wire [1:0]  rx_keepalive_i, // rx keep-alive
  input wire [1:0]  rx_valid_i,     // rx strobe
  input wire [31:0] mem_wr_data_o,  // mem word
  input wire [1:0]  mem_wr_o,       // mem write
  input wire [1:0]  crc_err_o,      // crc error
  input wire [1:0]  data_fail_o,    // mismatch
  input wire [1:0]  link_failed_o,  // failed
  input wire [1:0]  silence_o       // silence
);
  function automatic [15:0] crc16(input [31:0] d);
    reg [15:0] c;
    c = 16'hffff;
    for (int k = 31; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  wire crc_ok = rx_crc_i[15:0] == crc16({rx_true_i[15:0], rx_inv_i[15:0]});
  wire same   = rx_inv_i[15:0] == ~rx_true_i[15:0];
  reg  [31:0] idle;
  // idle cycles with nothing requested and nothing offered
  always @(posedge ref_clk_i)
    idle <= (!reset_n_i || app_tx_valid_i || tx_valid_o[0]) ? 0 : idle + 1;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rx0;
    rx_valid_i[0] && crc_ok;
  endsequence
  property p_lines; tx_valid_o[0] == tx_valid_o[1]; endproperty
  property p_hold;
    tx_valid_o[0] && !tx_ready_i |=> tx_valid_o[0] && $stable(tx_true_o);
  endproperty
  property p_crc;
    rx_valid_i[0] && !crc_ok |=> crc_err_o[0] && !mem_wr_o[0];
  endproperty
  property p_wr;
    s_rx0 ##0 (same && !rx_keepalive_i[0]) |=>
      mem_wr_o[0] && mem_wr_data_o[15:0] == $past(rx_true_i[15:0]);
  endproperty
  property p_mis; s_rx0 ##0 !same |=> data_fail_o[0] && !mem_wr_o[0];
  endproperty
  // recovery lands one cycle after the strobe that completes the clean run
  property p_keep;
    link_failed_o[1] && !rx_valid_i[1] && !$past(rx_valid_i[1]) |=>
      link_failed_o[1];
  endproperty
  property p_sil; silence_o[0] |-> link_failed_o[0]; endproperty
  property p_ka; idle <= KEEPALIVE_CYC + 8; endproperty
  a_lines: assert property (p_lines) else $error("lines differ");
  a_hold: assert property (p_hold) else $error("frame moved");
  a_crc: assert property (p_crc) else $error("crc not handled");
  a_wr: assert property (p_wr) else $error("good word lost");
  a_mis: assert property (p_mis) else $error("mismatch missed");
  a_keep: assert property (p_keep) else $error("fail dropped");
  a_sil: assert property (p_sil) else $error("silence unflagged");
  a_ka: assert property (p_ka) else $error("no keep-alive");
endmodule // link_health_checker
bind serial_link_health_supervisor link_health_checker #(
  .KEEPALIVE_CYC(KEEPALIVE_CYC)) chk (.ref_clk_i, .reset_n_i,
  .app_tx_valid_i, .tx_true_o, .tx_valid_o, .tx_ready_i, .rx_true_i,
  .rx_inv_i, .rx_crc_i, .rx_keepalive_i, .rx_valid_i, .mem_wr_data_o,
  .mem_wr_o, .crc_err_o, .data_fail_o, .link_failed_o, .silence_o);

// ### tb/peer_link_model.sv
// far-side link partner: takes frames and sends frames
`timescale 1ns/1ps
module peer_link_model (
  input  wire        ref_clk_i,  // clock
  input  wire        stall_i,    // hold off
  input  wire [1:0]  tx_valid_i, // offered
  input  wire [15:0] tx_true_i,  // true
  input  wire [15:0] tx_inv_i,   // inverse
  input  wire [15:0] tx_crc_i,   // crc
  input  wire        tx_ka_i,    // keep-alive
  output reg         tx_ready_o, // taken
  output reg  [31:0] rx_true_o,  // true
  output reg  [31:0] rx_inv_o,   // inverse
  output reg  [31:0] rx_crc_o,   // crc
  output reg  [1:0]  rx_ka_o,    // keep-alive
  output reg  [1:0]  rx_valid_o  // strobe
);
  logic [48:0] got[$];
  function automatic [15:0] crc16(input [31:0] d);
    reg [15:0] c;
    c = 16'hffff;
    for (int k = 31; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  initial begin
    tx_ready_o = 0;
    {rx_true_o, rx_inv_o, rx_crc_o, rx_ka_o, rx_valid_o} = 0;
  end
  always @(negedge ref_clk_i)
    tx_ready_o <= !stall_i && tx_valid_i == 2'b11 && !tx_ready_o;
  always @(posedge ref_clk_i)
    if (tx_valid_i[0] && tx_ready_o)
      got.push_back({tx_ka_i, tx_true_i, tx_inv_i, tx_crc_i});
  task send(input int g, input [15:0] t, input [15:0] i, input bad,
            input ka);
    @(negedge ref_clk_i);
    rx_true_o[g*16 +: 16] = t;
    rx_inv_o[g*16 +: 16] = i;
    rx_crc_o[g*16 +: 16] = crc16({t, i}) ^ {15'h0000, bad};
    rx_ka_o[g] = ka;
    rx_valid_o[g] = 1;
    @(negedge ref_clk_i);
    rx_valid_o[g] = 0;
    // released lines show no stale frame
    {rx_true_o, rx_inv_o, rx_crc_o} = ~{rx_true_o, rx_inv_o, rx_crc_o};
  endtask
endmodule // peer_link_model

// ### tb/serial_link_health_supervisor_tb.sv
// self-checking bench for the link health supervisor
`timescale 1ns/1ps
module serial_link_health_supervisor_tb;
  localparam KA = 50;
  logic        ref_clk_i = 0, reset_n_i = 0, app_tx_valid_i = 0, stall = 0;
  logic [15:0] app_tx_data_i = 16'h0000, tx_true_o, tx_inv_o, tx_crc_o;
  logic [31:0] rx_true_i, rx_inv_i, rx_crc_i, mem_wr_data_o;
  logic [1:0]  tx_valid_o, rx_keepalive_i, rx_valid_i, mem_wr_o;
  logic [1:0]  crc_err_o, data_fail_o, link_failed_o, silence_o;
  logic [1:0]  burst_fail_o;
  logic        app_tx_ready_o, tx_keepalive_o, tx_ready_i;
  integer      failures = 0, compares = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  serial_link_health_supervisor #(.KEEPALIVE_CYC(KA), .SILENCE_CYC(500))
  dut (.ref_clk_i, .reset_n_i, .app_tx_data_i, .app_tx_valid_i,
    .app_tx_ready_o, .tx_true_o, .tx_inv_o, .tx_crc_o, .tx_valid_o,
    .tx_keepalive_o, .tx_ready_i, .rx_true_i, .rx_inv_i, .rx_crc_i,
    .rx_keepalive_i, .rx_valid_i, .mem_wr_data_o, .mem_wr_o, .crc_err_o,
    .data_fail_o, .link_failed_o, .silence_o, .burst_fail_o);
  peer_link_model peer (.ref_clk_i, .stall_i(stall), .tx_valid_i(tx_valid_o),
    .tx_true_i(tx_true_o), .tx_inv_i(tx_inv_o), .tx_crc_i(tx_crc_o),
    .tx_ka_i(tx_keepalive_o), .tx_ready_o(tx_ready_i),
    .rx_true_o(rx_true_i), .rx_inv_o(rx_inv_i), .rx_crc_o(rx_crc_i),
    .rx_ka_o(rx_keepalive_i), .rx_valid_o(rx_valid_i));
  task chk(input [63:0] got, input [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tmo(input bit bad);
    if (bad) begin
      failures++;
      close_out;
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // fill the buffer against a stalled link, then drain it in order
  task t_tx_buffer;
    int k, n;
    reg [15:0] w;
    stall = 1;
    n = 0;
    for (k = 0; k < 12; k++) begin
      if (app_tx_ready_o === 1'b1) begin
        app_tx_data_i = 16'hc300 + n[15:0];
        app_tx_valid_i = 1;
        n++;
      end
      step(1);
      app_tx_valid_i = 0;
      step(1);
    end
    chk({app_tx_ready_o, tx_valid_o, peer.got.size() == 0}, 4'h7);
    stall = 0;
    for (k = 0; k < 40 && peer.got.size() < n; k++) step(1);
    tmo(peer.got.size() < n || n < 2);
    for (k = 0; k < n; k++) begin
      w = 16'hc300 + k[15:0];
      chk(peer.got[k], {1'b0, w, ~w, peer.crc16({w, ~w})});
    end
  endtask
  task t_keepalive;
    int k;
    peer.got.delete();
    for (k = 0; k < 2 * KA && peer.got.size() == 0; k++) step(1);
    tmo(peer.got.size() == 0);
    chk(peer.got[0], {17'h10000, 16'hffff, peer.crc16(32'hffff)});
  endtask
  // good, bad crc, copy mismatch and keep-alive frames on link 0
  task t_rx_kinds;
    int k;
    reg [15:0] t;
    for (k = 0; k < 4; k++) begin
      t = (k == 3) ? 16'h0000 : 16'h5a00 + k[15:0];
      peer.send(0, t, (k == 2) ? t : ~t, k == 1, k == 3);
      chk({mem_wr_o[0], crc_err_o[0], data_fail_o[0]},
          (k == 0) ? 4 : (k == 1) ? 2 : (k == 2) ? 1 : 0);
      if (k == 0) chk(mem_wr_data_o[15:0], t);
    end
  endtask
  task t_burst;
    int k;
    for (k = 0; k < 4; k++) begin
      chk(link_failed_o[1], 0);
      peer.send(1, 16'h0f0f, 16'hf0f0, 1, 0);
    end
    step(1);
    chk({burst_fail_o[1], link_failed_o[1]}, 2'b11);
    for (k = 0; k < 100; k++) begin
      chk(link_failed_o[1], 1);
      peer.send(1, 16'h3c3c, 16'hc3c3, 0, 0);
    end
    step(1);
    chk({burst_fail_o[1], link_failed_o[1]}, 2'b00);
  endtask
  task t_silence;
    int k;
    chk(silence_o, 2'b00);
    for (k = 0; k < 600 && silence_o !== 2'b11; k++) step(1);
    tmo(silence_o !== 2'b11);
    chk({k > 490 && k < 510, link_failed_o}, 3'b111);
  endtask
  initial begin
    step(4);
    chk({app_tx_ready_o, tx_valid_o, link_failed_o, mem_wr_o}, 0);
    reset_n_i = 1;
    t_tx_buffer;
    t_keepalive;
    t_rx_kinds;
    t_burst;
    t_silence;
    close_out;
  end
endmodule // serial_link_health_supervisor_tb
